// ### verilog/nwp_pkg.sv
package nwp_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_TIME_NS = 2000000;   // Self-timed write cycle
  localparam int PWRT_TIME_NS = 72000000;   // Power-up timer span
  localparam int WRITE_CYCLES =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRT_CYCLES =
    (PWRT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 22;
  localparam int SYNC_CYCLES = 2;           // Pin synchroniser depth

  // ************************************************************
  // Register bus
  // ************************************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_UNLOCK = 3'h1;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h2;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h3;
  localparam logic [2:0] OFS_CONFIG = 3'h4;

  // Control register fields
  localparam int CTL_START = 1;
  localparam int CTL_WRITE_ENABLE_BIT = 2;
  localparam int CTL_ERR = 3;
  localparam int CTL_PMSEL = 7;

  // Interrupt status and mask fields
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // Configuration word fields (1 = unprotected, erased state)
  localparam int CFG_DPROT = 0;
  localparam int CFG_CPLO = 1;
  localparam int CFG_CPHI = 2;
  localparam int CFG_WPROT = 3;
  localparam int CFG_W = 4;
  localparam int CFG_PWRT_RUN = 4;          // Config read bit: timer busy
  localparam logic [3:0] CFG_ERASED = 4'hF;

  // Unlock values
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // ************************************************************
  // Unlock sequence states
  // ************************************************************
  typedef enum logic [1:0] {
    NWP_UL_IDLE = 2'b00,
    NWP_UL_FIRST = 2'b01,
    NWP_UL_ARMED = 2'b10
  } nwp_unlock_t;

endpackage

// ### verilog/nwp_protect.sv
`timescale 1ns/1ps

// Function
// - Write starts only with enable set, then 55h, AAh, then start.
// - No automatic read-back compare after a write finishes.
// - Reset clears the write enable bit.
// - Running power-up timer, when enabled, blocks all firmware writes; serial configuration writes still go through.
// - Data EEPROM firmware access ignores the data protect bit.
// - Data protect active refuses serial reads and writes; serial erase still works.
// - Program protect bits never hinder fetch or internal reads.
// - Code protection stays until a full device erase or a reset.
// - Write protect bit reachable only from the serial port.
// - Write protect rejects firmware program memory writes selected before the start write.
// - Write protect leaves program memory reads untouched.
// - Write protect stays enabled until full device erase or reset.
// - Write end clears start bit and sets sticky done flag.
// - Core stalls through a program write whose select was set before the start write.
module nwp_protect #(
  parameter int WRITE_CYC = nwp_pkg::WRITE_CYCLES,
  parameter int PWRT_CYC = nwp_pkg::PWRT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [nwp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [nwp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [nwp_pkg::DATA_W-1:0] reg_rdata,
  // Interrupt
  output logic irq,
  // Power-up timer strap pin
  input wire logic pwrt_enable_pin,
  // Serial programming port pins
  input wire logic ser_cfg_write_pin,
  input wire logic [nwp_pkg::CFG_W-1:0] ser_cfg_data_pin,
  input wire logic ser_erase_pin,
  output logic ser_read_grant,
  output logic ser_write_grant,
  output logic [nwp_pkg::CFG_W-1:0] ser_cfg_rdata,
  // Array and core side
  output logic array_write_start,
  output logic array_program_select,
  output logic write_busy,
  output logic core_stall,
  output logic program_read_allow
);
  import nwp_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int SYN_W = CFG_W + 3;

  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic syn_wr_prev_q;
  logic syn_er_prev_q;

  // Two stages for every pin input
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      syn1_q <= '0;
      syn2_q <= '0;
      syn_wr_prev_q <= 1'b0;
      syn_er_prev_q <= 1'b0;
    end
    else
    begin
      syn1_q <= {pwrt_enable_pin, ser_erase_pin, ser_cfg_write_pin,
                 ser_cfg_data_pin};
      syn2_q <= syn1_q;
      syn_wr_prev_q <= syn2_q[CFG_W];
      syn_er_prev_q <= syn2_q[CFG_W+1];
    end
  end

  logic pwrt_en_s;
  logic ser_wr_rise;
  logic ser_er_rise;
  logic [CFG_W-1:0] ser_data_s;

  // Edge detection on the second stage only
  assign pwrt_en_s = syn2_q[CFG_W+2];
  assign ser_er_rise = syn2_q[CFG_W+1] & ~syn_er_prev_q;
  assign ser_wr_rise = syn2_q[CFG_W] & ~syn_wr_prev_q;
  assign ser_data_s = syn2_q[CFG_W-1:0];

  // ************************************************************
  // Register bus decode
  // ************************************************************
  logic wr_ctl;
  logic wr_unl;
  logic wr_msk;
  logic rd_sts;

  // Strobes qualified by address
  assign wr_ctl = reg_we && (reg_addr == OFS_CONTROL);
  assign wr_unl = reg_we && (reg_addr == OFS_UNLOCK);
  assign wr_msk = reg_we && (reg_addr == OFS_IRQ_MASK);
  assign rd_sts = reg_re && (reg_addr == OFS_IRQ_STATUS);

  // ************************************************************
  // State registers
  // ************************************************************
  logic [CFG_W-1:0] cfg_q;
  logic [CFG_W-1:0] cfg_d;
  nwp_unlock_t ul_q;
  nwp_unlock_t ul_d;
  logic write_enable_bit_q;
  logic write_enable_bit_d;
  logic pmsel_q;
  logic pmsel_d;
  logic start_q;
  logic start_d;
  logic err_q;
  logic err_d;
  logic [CNT_W-1:0] wcnt_q;
  logic [CNT_W-1:0] wcnt_d;
  logic [CNT_W-1:0] pcnt_q;
  logic [CNT_W-1:0] pcnt_d;
  logic pwrt_run_q;
  logic pwrt_run_d;
  logic [IRQ_W-1:0] sts_q;
  logic [IRQ_W-1:0] sts_d;
  logic [IRQ_W-1:0] msk_q;
  logic [IRQ_W-1:0] msk_d;
  logic irq_q;
  logic irq_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic astart_q;
  logic astart_d;
  logic stall_q;
  logic stall_d;
  logic srd_q;
  logic srd_d;
  logic swr_q;
  logic swr_d;
  logic nrst_seen_q;

  logic start_req;
  logic start_ok;
  logic wp_block;
  logic wr_end;

  // ************************************************************
  // Configuration word held for the serial port
  // ************************************************************
  // Serial writes can only clear bits; only erase or reset sets them again
  always_comb
  begin
    cfg_d = cfg_q;
    if (ser_er_rise)
      cfg_d = CFG_ERASED;
    else if (ser_wr_rise && swr_q)
      cfg_d = cfg_q & ser_data_s;
  end

  // Serial access grants from the protect bits
  always_comb
  begin
    srd_d = cfg_q[CFG_DPROT] &&
            (cfg_q[CFG_CPHI] || cfg_q[CFG_CPLO]);
    swr_d = cfg_q[CFG_DPROT] && cfg_q[CFG_CPHI] &&
            cfg_q[CFG_CPLO];
  end

  // ************************************************************
  // Power-up timer
  // ************************************************************
  // Strap is sampled after release; until then writes stay blocked
  always_comb
  begin
    pcnt_d = pcnt_q;
    pwrt_run_d = pwrt_run_q;
    if (pwrt_run_q)
    begin
      if (pcnt_q >= CNT_W'(PWRT_CYC - 1))
        pwrt_run_d = 1'b0;
      else if (!pwrt_en_s && pcnt_q >= CNT_W'(SYNC_CYCLES))
        pwrt_run_d = 1'b0;                      // Strap low once settled
      else
        pcnt_d = pcnt_q + CNT_W'(1);
    end
  end

  // ************************************************************
  // Unlock sequence
  // ************************************************************
  // Any other register write breaks the sequence
  always_comb
  begin
    ul_d = ul_q;
    if (reg_we)
    begin
      case (ul_q)
        NWP_UL_IDLE:
        begin
          if (wr_unl && reg_wdata == UNLOCK_FIRST)
            ul_d = NWP_UL_FIRST;
        end
        NWP_UL_FIRST:
        begin
          if (wr_unl && reg_wdata == UNLOCK_SECOND)
            ul_d = NWP_UL_ARMED;
          else if (wr_unl && reg_wdata == UNLOCK_FIRST)
            ul_d = NWP_UL_FIRST;
          else
            ul_d = NWP_UL_IDLE;
        end
        NWP_UL_ARMED:
          ul_d = NWP_UL_IDLE;
        default:
          ul_d = NWP_UL_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Write control
  // ************************************************************
  assign start_req = wr_ctl && reg_wdata[CTL_START] && !start_q;
  assign wp_block = pmsel_q && !cfg_q[CFG_WPROT];
  assign start_ok = start_req && write_enable_bit_q && (ul_q == NWP_UL_ARMED) &&
                    !pwrt_run_q && !wp_block;
  assign wr_end = start_q && (wcnt_q >= CNT_W'(WRITE_CYC - 1));

  // Control bits, write cycle counter and array strobes
  always_comb
  begin
    write_enable_bit_d = write_enable_bit_q;
    pmsel_d = pmsel_q;
    start_d = start_q;
    err_d = err_q;
    wcnt_d = wcnt_q;
    astart_d = 1'b0;
    stall_d = stall_q;
    if (wr_ctl)
    begin
      write_enable_bit_d = reg_wdata[CTL_WRITE_ENABLE_BIT];
      if (!start_q)
        pmsel_d = reg_wdata[CTL_PMSEL];         // Held during a cycle
      if (!reg_wdata[CTL_ERR])
        err_d = 1'b0;
    end
    if (start_ok)
    begin
      start_d = 1'b1;
      wcnt_d = '0;
      astart_d = 1'b1;
      stall_d = pmsel_q;
    end
    else if (start_req && ul_q == NWP_UL_ARMED && write_enable_bit_q)
      err_d = 1'b1;
    if (start_q)
    begin
      if (wr_end)
      begin
        start_d = 1'b0;
        stall_d = 1'b0;
      end
      else
        wcnt_d = wcnt_q + CNT_W'(1);
    end
    // End of cycle just ends; no compare of written data
  end

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  // Read clears; a new event in the same cycle wins
  always_comb
  begin
    sts_d = sts_q;
    msk_d = msk_q;
    if (rd_sts)
      sts_d = '0;
    if (wr_end)
      sts_d[IRQ_DONE] = 1'b1;
    if (start_req && !start_ok && ul_q == NWP_UL_ARMED && write_enable_bit_q)
      sts_d[IRQ_ERR] = 1'b1;
    if (wr_msk)
      msk_d = reg_wdata[IRQ_W-1:0];
    irq_d = |(sts_d & msk_d);
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Unmapped and write-only offsets read as zero
  always_comb
  begin
    rdata_d = '0;
    if (reg_re)
    begin
      case (reg_addr)
        OFS_CONTROL:
        begin
          rdata_d[CTL_PMSEL] = pmsel_q;
          rdata_d[CTL_ERR] = err_q;
          rdata_d[CTL_WRITE_ENABLE_BIT] = write_enable_bit_q;
          rdata_d[CTL_START] = start_q;
        end
        OFS_IRQ_STATUS:
          rdata_d[IRQ_W-1:0] = sts_q;
        OFS_IRQ_MASK:
          rdata_d[IRQ_W-1:0] = msk_q;
        OFS_CONFIG:
        begin
          rdata_d[CFG_W-1:0] = cfg_q;           // Read only
          rdata_d[CFG_PWRT_RUN] = pwrt_run_q;
        end
        default:
          rdata_d = '0;
      endcase
    end
  end

  // ************************************************************
  // Register stage
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      cfg_q <= CFG_ERASED;
      ul_q <= NWP_UL_IDLE;
      write_enable_bit_q <= 1'b0;
      pmsel_q <= 1'b0;
      start_q <= 1'b0;
      err_q <= 1'b0;
      wcnt_q <= '0;
      pcnt_q <= '0;
      pwrt_run_q <= 1'b1;
      sts_q <= '0;
      msk_q <= IRQ_MASK_RST;
      irq_q <= 1'b0;
      rdata_q <= '0;
      astart_q <= 1'b0;
      stall_q <= 1'b0;
      srd_q <= 1'b0;
      swr_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      ul_q <= ul_d;
      write_enable_bit_q <= write_enable_bit_d;
      pmsel_q <= pmsel_d;
      start_q <= start_d;
      err_q <= err_d;
      wcnt_q <= wcnt_d;
      pcnt_q <= pcnt_d;
      pwrt_run_q <= pwrt_run_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      astart_q <= astart_d;
      stall_q <= stall_d;
      srd_q <= srd_d;
      swr_q <= swr_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign ser_read_grant = srd_q;
  assign ser_write_grant = swr_q;
  assign ser_cfg_rdata = cfg_q;
  assign array_write_start = astart_q;
  assign array_program_select = pmsel_q;
  assign write_busy = start_q;
  assign core_stall = stall_q;
  // Fetch and table reads never gated by protect bits
  assign program_read_allow = nrst_seen_q;

  // Read permission from the first clock edge onward, in reset or not
  always_ff @(posedge clock)
  begin
    if (!nrst)
      nrst_seen_q <= 1'b1;
    else
      nrst_seen_q <= 1'b1;
  end

endmodule

// ### dv/nwp_protect_chk.sv
`timescale 1ns/1ps
// Port-level checker for the write guard
module nwp_protect_chk #(
  parameter int WRITE_CYC = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [nwp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [nwp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [nwp_pkg::DATA_W-1:0] reg_rdata,
  // Serial programming port
  input wire logic ser_erase_pin,
  input wire logic ser_read_grant,
  input wire logic ser_write_grant,
  input wire logic [nwp_pkg::CFG_W-1:0] ser_cfg_rdata,
  // Array and core side
  input wire logic array_write_start,
  input wire logic array_program_select,
  input wire logic write_busy,
  input wire logic core_stall,
  input wire logic program_read_allow
);
  import nwp_pkg::*;
  localparam int WMAX = WRITE_CYC + 4;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ************************************************************
  // Write cycle steps
  // ************************************************************
  sequence s_hold;
    write_busy [*4];
  endsequence
  sequence s_end;
    !write_busy && !core_stall;
  endsequence
  // Start only from a start-bit write to control
  a_start_cause: assert property (array_write_start |-> $past(reg_we) &&
    $past(reg_addr) == OFS_CONTROL && $past(reg_wdata[CTL_START]))
    else $error("start without control write");
  // Busy holds four cycles, then ends within WRITE_CYC+4 more cycles
  a_busy_end: assert property ($rose(write_busy) |-> s_hold ##[1:WMAX] s_end)
    else $error("write cycle length wrong");
  // No second start right after a write ends
  a_no_verify: assert property ($fell(write_busy) |-> !array_write_start)
    else $error("extra start after write");
  // Stall only during program writes
  a_stall_prog: assert property (core_stall |-> write_busy && array_program_select)
    else $error("stall outside program write");
  // Program reads never gated
  a_read_open: assert property (program_read_allow)
    else $error("program read gated");
  // Data protect locks the serial port
  a_dprot_lock: assert property (!ser_cfg_rdata[CFG_DPROT] &&
    !$past(ser_cfg_rdata[CFG_DPROT]) |-> !ser_read_grant && !ser_write_grant)
    else $error("serial grant under data protect");
  // Write grant implies read grant
  a_grant_nest: assert property (ser_write_grant |-> ser_read_grant)
    else $error("write grant without read grant");
  // Protection bits return only by erase
  a_prot_sticky: assert property ($past(nrst) &&
    |(ser_cfg_rdata & ~$past(ser_cfg_rdata)) |-> ser_erase_pin)
    else $error("protection lifted without erase");
  // Write protect bars program starts
  a_wprot_start: assert property (array_write_start &&
    !ser_cfg_rdata[CFG_WPROT] |-> !array_program_select)
    else $error("program write under write protect");
  // Read data only after a read strobe
  a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule

bind nwp_protect nwp_protect_chk #(.WRITE_CYC(WRITE_CYC)) u_chk (
  .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .ser_erase_pin(ser_erase_pin), .ser_read_grant(ser_read_grant),
  .ser_write_grant(ser_write_grant), .ser_cfg_rdata(ser_cfg_rdata),
  .array_write_start(array_write_start),
  .array_program_select(array_program_select), .write_busy(write_busy),
  .core_stall(core_stall), .program_read_allow(program_read_allow));

// ### dv/nwp_ser_prog.sv
`timescale 1ns/1ps
// Serial programmer model on the programming pins
module nwp_ser_prog (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic do_write,
  input wire logic do_erase,
  input wire logic [nwp_pkg::CFG_W-1:0] data,
  // Programming pins
  output logic ser_cfg_write_pin,
  output logic ser_erase_pin,
  output logic [nwp_pkg::CFG_W-1:0] ser_cfg_data_pin
);
  logic [3:0] hold_q = 4'h0;
  // Pins idle low at time zero
  initial
  begin
    ser_cfg_write_pin = 1'b0;
    ser_erase_pin = 1'b0;
    ser_cfg_data_pin = 4'h0;
  end
  // Each pulse holds nine cycles so the synchronisers see it
  always @(posedge clock)
  begin
    if (do_write || do_erase)
    begin
      hold_q <= 4'h8;
      ser_cfg_write_pin <= do_write;
      ser_erase_pin <= do_erase;
      ser_cfg_data_pin <= data;
    end
    else if (hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
    else
    begin
      ser_cfg_write_pin <= 1'b0;
      ser_erase_pin <= 1'b0;
      ser_cfg_data_pin <= ~ser_cfg_data_pin; // Released data keeps moving
    end
  end
endmodule

// ### dv/nwp_protect_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("Error %s exp %0h got %0h", n, e, g); \
    end \
  end
module nwp_protect_tb_top;
  import nwp_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic pwrt_enable_pin = 1'b0;
  logic ser_cfg_write_pin;
  logic [3:0] ser_cfg_data_pin;
  logic ser_erase_pin;
  logic ser_read_grant;
  logic ser_write_grant;
  logic [3:0] ser_cfg_rdata;
  logic array_write_start;
  logic array_program_select;
  logic write_busy;
  logic core_stall;
  logic program_read_allow;
  logic do_write = 1'b0;
  logic do_erase = 1'b0;
  logic [3:0] prog_data = 4'h0;
  int fails = 0;
  int checked = 0;
  int starts = 0;
  int i;
  logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00,
    8'h00, 8'h00};
  // Clock and start pulse count
  always #20 clock = ~clock;
  always @(posedge clock)
    if (array_write_start === 1'b1)
      starts++;
  // Design and serial programmer
  nwp_protect #(.WRITE_CYC(8), .PWRT_CYC(20)) u_dut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq),
    .pwrt_enable_pin(pwrt_enable_pin), .ser_cfg_write_pin(ser_cfg_write_pin),
    .ser_cfg_data_pin(ser_cfg_data_pin), .ser_erase_pin(ser_erase_pin),
    .ser_read_grant(ser_read_grant), .ser_write_grant(ser_write_grant),
    .ser_cfg_rdata(ser_cfg_rdata), .array_write_start(array_write_start),
    .array_program_select(array_program_select), .write_busy(write_busy),
    .core_stall(core_stall), .program_read_allow(program_read_allow));
  nwp_ser_prog u_prog (.clock(clock), .do_write(do_write),
    .do_erase(do_erase), .data(prog_data),
    .ser_cfg_write_pin(ser_cfg_write_pin), .ser_erase_pin(ser_erase_pin),
    .ser_cfg_data_pin(ser_cfg_data_pin));
  // Register port cycles
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_we <= 1'b1;
    reg_re <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask
  task idle(input int n);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e, input string n);
    reg_re <= 1'b1;
    reg_we <= 1'b0;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1 `CHK(n, e, reg_rdata)
  endtask
  // Unlock pair, start write, then two idle cycles
  task unlock_start(input logic [7:0] ctl);
    wr(OFS_UNLOCK, UNLOCK_FIRST);
    wr(OFS_UNLOCK, UNLOCK_SECOND);
    wr(OFS_CONTROL, ctl);
    idle(2);
  endtask
  task wait_idle;
    int j;
    j = 0;
    while (write_busy !== 1'b0 && j < 40)
    begin
      @(posedge clock);
      j++;
    end
    `CHK("write end", 1'b0, write_busy)
    #1;
  endtask
  // Serial programmer command, then time for the sync path
  task prog(input logic w, input logic [3:0] d);
    do_write <= w;
    do_erase <= ~w;
    prog_data <= d;
    @(posedge clock);
    do_write <= 1'b0;
    do_erase <= 1'b0;
    repeat (14) @(posedge clock);
    #1;
  endtask
  task give_verdict;
    $display("Checks %0d, errors %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #120000;
    fails++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    idle(6);
    // Reset value table, unmapped offsets read zero
    for (i = 0; i < 8; i++)
      rd(3'(i), rst_exp[i], "reset read");
    `CHK("grants", 2'b11, {ser_read_grant, ser_write_grant})
    // Data write with done interrupt unmasked
    wr(OFS_IRQ_MASK, 8'h03);
    wr(OFS_CONTROL, 8'h04);
    unlock_start(8'h06);
    `CHK("data busy", 2'b10, {write_busy, core_stall})
    wait_idle;
    `CHK("done irq", 1'b1, irq)
    rd(OFS_IRQ_STATUS, 8'h01, "status");
    rd(OFS_IRQ_STATUS, 8'h00, "status clr");
    `CHK("irq low", 1'b0, irq)
    rd(OFS_CONTROL, 8'h04, "ctl after");
    `CHK("one start", 1, starts)
    // Program write with interrupt masked
    wr(OFS_IRQ_MASK, 8'h00);
    wr(OFS_CONTROL, 8'h84);
    unlock_start(8'h86);
    `CHK("stall", 3'b111, {write_busy, core_stall, array_program_select})
    wait_idle;
    idle(1);
    `CHK("masked irq", 1'b0, irq)
    wr(OFS_IRQ_MASK, 8'h01);
    idle(2);
    `CHK("unmasked irq", 1'b1, irq)
    rd(OFS_IRQ_STATUS, 8'h01, "status prog");
    // Broken unlock orders and missing enable start nothing
    for (i = 0; i < 2; i++)
    begin
      wr(OFS_UNLOCK, UNLOCK_FIRST);
      if (i == 0)
        wr(OFS_IRQ_MASK, 8'h01);
      wr(OFS_UNLOCK, UNLOCK_SECOND);
      if (i == 1)
        wr(OFS_IRQ_MASK, 8'h01);
      wr(OFS_CONTROL, 8'h06);
      idle(2);
    end
    wr(OFS_CONTROL, 8'h00);
    unlock_start(8'h02);
    `CHK("broken unlock", 2, starts)
    // Firmware cannot change the configuration
    wr(OFS_CONFIG, 8'h00);
    idle(2);
    `CHK("cfg fw", 4'hF, ser_cfg_rdata)
    // Write protect refuses program writes, data writes still run
    prog(1'b1, 4'h7);
    `CHK("wprot cfg", 4'h7, ser_cfg_rdata)
    wr(OFS_CONTROL, 8'h84);
    unlock_start(8'h86);
    `CHK("wprot start", 2, starts)
    rd(OFS_CONTROL, 8'h8C, "refused ctl");
    rd(OFS_IRQ_STATUS, 8'h02, "refused st");
    `CHK("read allow", 1'b1, program_read_allow)
    wr(OFS_CONTROL, 8'h04);
    unlock_start(8'h06);
    wait_idle;
    `CHK("data wprot", 3, starts)
    // Data protect locks the serial port until erase
    prog(1'b1, 4'h6);
    `CHK("dprot grants", 2'b00, {ser_read_grant, ser_write_grant})
    wr(OFS_CONTROL, 8'h04);
    unlock_start(8'h06);
    wait_idle;
    `CHK("data dprot", 4, starts)
    prog(1'b1, 4'h0);
    `CHK("locked cfg", 4'h6, ser_cfg_rdata)
    prog(1'b0, 4'h0);
    `CHK("erased cfg", 4'hF, ser_cfg_rdata)
    `CHK("erase grants", 2'b11, {ser_read_grant, ser_write_grant})
    // Power-up timer blocks writes after a fresh reset
    pwrt_enable_pin <= 1'b1;
    nrst <= 1'b0;
    idle(4);
    nrst <= 1'b1;
    rd(OFS_CONFIG, 8'h1F, "timer busy");
    rd(OFS_CONTROL, 8'h00, "write_enable_bit reset");
    wr(OFS_CONTROL, 8'h04);
    unlock_start(8'h06);
    `CHK("timer block", 4, starts)
    idle(25);
    rd(OFS_CONFIG, 8'h0F, "timer done");
    give_verdict;
  end
endmodule
